// ==== src/radio_frontend_synth_cfg_regs.sv ====
// Design: configuration register bank for front-end bias and synthesizer calibration
// Behaviour
// - Power index selects one of two table entries
// - Zero pump enable field skips pump calibration
// - Low four bits hold pump current code
// - Core select bit chooses high or low oscillator
// - Oscillator current field: calibration result and override
// - Coarse tuning field holds capacitor array setting
// - Wake forces internal test value 0x88 or 0x81
// - Test register reads 0x88 after wake
// - First reserved register resets 11111_0_00, bit2 unused
module radio_frontend_synth_cfg_regs #(
  parameter int TABLE_DEPTH = synth_cfg_pkg::POWER_TABLE_DEPTH
) (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       wr_en,
  input  wire logic       rd_en,
  input  wire logic [5:0] addr,
  input  wire logic [7:0] wr_data,
  output logic      [7:0] rd_data,
  output logic            rd_hit,
  input  wire logic       sleep_active,
  input  wire logic       wake_event,
  input  wire logic       converter_retention_option,
  input  wire logic       cal_result_valid,
  input  wire logic [3:0] cal_pump_code,
  input  wire logic [4:0] cal_osc_current,
  input  wire logic [5:0] cal_coarse,
  input  wire logic [7:0] power_entry_0,
  input  wire logic [7:0] power_entry_1,
  output logic      [7:0] selected_power,
  output logic      [2:0] amp_power_index,
  output logic            pump_cal_stage_enable,
  output logic      [3:0] pump_current_code,
  output logic            osc_core_high_select,
  output logic      [4:0] osc_current_code,
  output logic      [5:0] coarse_tune_code,
  output logic      [7:0] rx_bias,
  output logic      [6:0] cal_control,
  output logic      [7:0] tuning_b,
  output logic      [7:0] tuning_c,
  output logic      [7:0] tuning_d,
  output logic      [7:0] test_two_analog
);

  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  // Two table entries arrive as ports, so no other depth can be served
  if (TABLE_DEPTH != 2) begin
    $error("power table depth must be 2");
  end

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [7:0] res_a_ff;
  logic [7:0] rx_bias_ff;
  logic [7:0] tx_bias_ff;
  logic [7:0] cal_pump_ff;
  logic [7:0] cal_osc_ff;
  logic [7:0] cal_coarse_ff;
  logic [7:0] cal_ctrl_ff;
  logic [7:0] res_b_ff;
  logic [7:0] res_c_ff;
  logic [7:0] res_d_ff;
  logic [7:0] test_read_ff;
  logic [7:0] test_analog_ff;
  logic [7:0] selected_power_ff;
  logic [7:0] rd_data_ff;
  logic       rd_hit_ff;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  function automatic logic hit(input logic [5:0] a, input logic [5:0] target, input logic we);
    hit = we && (a == target);
  endfunction

  logic wr_res_a;
  logic wr_rx_bias;
  logic wr_tx_bias;
  logic wr_cal_pump;
  logic wr_cal_osc;
  logic wr_cal_coarse;
  logic wr_cal_ctrl;
  logic wr_res_b;
  logic wr_res_c;
  logic wr_res_d;
  logic wr_test_two;
  logic vol_wr_ok;

  // Volatile registers take no writes while the device sleeps
  assign vol_wr_ok     = wr_en && !sleep_active;
  assign wr_res_a      = hit(addr, synth_cfg_pkg::ADDR_RES_A, wr_en);
  assign wr_rx_bias    = hit(addr, synth_cfg_pkg::ADDR_RX_BIAS, wr_en);
  assign wr_tx_bias    = hit(addr, synth_cfg_pkg::ADDR_TX_BIAS, wr_en);
  assign wr_cal_pump   = hit(addr, synth_cfg_pkg::ADDR_CAL_PUMP, wr_en);
  assign wr_cal_osc    = hit(addr, synth_cfg_pkg::ADDR_CAL_OSC, wr_en);
  assign wr_cal_coarse = hit(addr, synth_cfg_pkg::ADDR_CAL_COARSE, wr_en);
  assign wr_cal_ctrl   = hit(addr, synth_cfg_pkg::ADDR_CAL_CTRL, wr_en);
  assign wr_res_b      = hit(addr, synth_cfg_pkg::ADDR_RES_B, vol_wr_ok);
  assign wr_res_c      = hit(addr, synth_cfg_pkg::ADDR_RES_C, vol_wr_ok);
  assign wr_res_d      = hit(addr, synth_cfg_pkg::ADDR_RES_D, vol_wr_ok);
  assign wr_test_two   = hit(addr, synth_cfg_pkg::ADDR_TEST_TWO, vol_wr_ok);

  // ----------------------------------------
  // Retained configuration registers
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      res_a_ff <= synth_cfg_pkg::RST_RES_A;
    end else if (wr_res_a) begin
      res_a_ff <= wr_data & synth_cfg_pkg::MASK_RES_A;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_bias_ff <= synth_cfg_pkg::RST_RX_BIAS;
    end else if (wr_rx_bias) begin
      rx_bias_ff <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_bias_ff <= synth_cfg_pkg::RST_TX_BIAS;
    end else if (wr_tx_bias) begin
      tx_bias_ff <= wr_data & synth_cfg_pkg::MASK_TX_BIAS;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_ctrl_ff <= synth_cfg_pkg::RST_CAL_CTRL;
    end else if (wr_cal_ctrl) begin
      cal_ctrl_ff <= wr_data & synth_cfg_pkg::MASK_CAL_CTRL;
    end
  end

  // ----------------------------------------
  // Calibration registers: host override, calibration result wins
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cal_pump_ff   <= synth_cfg_pkg::RST_CAL_PUMP;
      cal_osc_ff    <= synth_cfg_pkg::RST_CAL_OSC;
      cal_coarse_ff <= synth_cfg_pkg::RST_CAL_COARSE;
    end else begin
      if (cal_result_valid) begin
        // A host write in the same cycle keeps only its configuration bits
        cal_pump_ff[3:0]   <= cal_pump_code;
        cal_osc_ff[4:0]    <= cal_osc_current;
        cal_coarse_ff[5:0] <= cal_coarse;
        if (wr_cal_pump) begin
          cal_pump_ff[7:4] <= wr_data[7:4];
        end
        if (wr_cal_osc) begin
          cal_osc_ff[7:5] <= wr_data[7:5] & synth_cfg_pkg::MASK_CAL_OSC[7:5];
        end
      end else begin
        if (wr_cal_pump) begin
          cal_pump_ff <= wr_data;
        end
        if (wr_cal_osc) begin
          cal_osc_ff <= wr_data & synth_cfg_pkg::MASK_CAL_OSC;
        end
        if (wr_cal_coarse) begin
          cal_coarse_ff <= wr_data & synth_cfg_pkg::MASK_CAL_COARSE;
        end
      end
    end
  end

  // ----------------------------------------
  // Volatile registers: lost in sleep, forced on wake
  // ----------------------------------------
  // Wake reloads the reset values; the host must then restore its settings
  always_ff @(posedge clk) begin
    if (sys_rst || wake_event) begin
      res_b_ff <= synth_cfg_pkg::RST_RES_B;
    end else if (wr_res_b) begin
      res_b_ff <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || wake_event) begin
      res_c_ff <= synth_cfg_pkg::RST_RES_C;
    end else if (wr_res_c) begin
      res_c_ff <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || wake_event) begin
      res_d_ff <= synth_cfg_pkg::RST_RES_D;
    end else if (wr_res_d) begin
      res_d_ff <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || wake_event) begin
      test_read_ff <= synth_cfg_pkg::RST_TEST_TWO;
    end else if (wr_test_two) begin
      test_read_ff <= wr_data;
    end
  end

  // ----------------------------------------
  // Internal analog copy of the test register
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      test_analog_ff <= synth_cfg_pkg::RST_TEST_TWO;
    end else if (wake_event) begin
      test_analog_ff <= converter_retention_option ? synth_cfg_pkg::WAKE_TEST_RET
                                                   : synth_cfg_pkg::RST_TEST_TWO;
    end else if (wr_test_two) begin
      test_analog_ff <= wr_data;
    end
  end

  // ----------------------------------------
  // Output power table selection
  // ----------------------------------------
  logic [7:0] power_table [TABLE_DEPTH];
  logic [2:0] power_idx;

  assign power_table[0] = power_entry_0;
  assign power_table[1] = power_entry_1;
  assign power_idx      = tx_bias_ff[synth_cfg_pkg::POWER_IDX_LSB +: 3];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      selected_power_ff <= 8'h00;
    end else if (power_idx < 3'(TABLE_DEPTH)) begin
      selected_power_ff <= power_table[power_idx[0]];
    end else begin
      // Indices beyond the table fall back to entry 0
      selected_power_ff <= power_table[0];
    end
  end

  // ----------------------------------------
  // Register read port
  // ----------------------------------------
  logic [7:0] nxt_rd_data;

  always_comb begin
    nxt_rd_data = 8'h00;
    case (addr)
      synth_cfg_pkg::ADDR_RES_A:      nxt_rd_data = res_a_ff;
      synth_cfg_pkg::ADDR_RX_BIAS:    nxt_rd_data = rx_bias_ff;
      synth_cfg_pkg::ADDR_TX_BIAS:    nxt_rd_data = tx_bias_ff;
      synth_cfg_pkg::ADDR_CAL_PUMP:   nxt_rd_data = cal_pump_ff;
      synth_cfg_pkg::ADDR_CAL_OSC:    nxt_rd_data = cal_osc_ff;
      synth_cfg_pkg::ADDR_CAL_COARSE: nxt_rd_data = cal_coarse_ff;
      synth_cfg_pkg::ADDR_CAL_CTRL:   nxt_rd_data = cal_ctrl_ff;
      synth_cfg_pkg::ADDR_RES_B:      nxt_rd_data = res_b_ff;
      synth_cfg_pkg::ADDR_RES_C:      nxt_rd_data = res_c_ff;
      synth_cfg_pkg::ADDR_RES_D:      nxt_rd_data = res_d_ff;
      synth_cfg_pkg::ADDR_TEST_TWO:   nxt_rd_data = test_read_ff;
      default:                        nxt_rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_data_ff <= 8'h00;
      rd_hit_ff  <= 1'b0;
    end else begin
      rd_hit_ff <= rd_en;
      if (rd_en) begin
        rd_data_ff <= nxt_rd_data;
      end
    end
  end

  // ----------------------------------------
  // Output ports
  // ----------------------------------------
  assign rd_data               = rd_data_ff;
  assign rd_hit                = rd_hit_ff;
  assign selected_power        = selected_power_ff;
  assign amp_power_index       = tx_bias_ff[synth_cfg_pkg::POWER_IDX_LSB +: 3];
  assign pump_cal_stage_enable = cal_pump_ff[synth_cfg_pkg::PUMP_EN_LSB +: 2] != 2'h0;
  assign pump_current_code     = cal_pump_ff[synth_cfg_pkg::PUMP_CODE_LSB +: 4];
  assign osc_core_high_select  = cal_osc_ff[synth_cfg_pkg::CORE_HIGH_BIT];
  assign osc_current_code      = cal_osc_ff[synth_cfg_pkg::OSC_CUR_LSB +: 5];
  assign coarse_tune_code      = cal_coarse_ff[synth_cfg_pkg::COARSE_LSB +: 6];
  assign rx_bias               = rx_bias_ff;
  assign cal_control           = cal_ctrl_ff[6:0];
  assign tuning_b              = res_b_ff;
  assign tuning_c              = res_c_ff;
  assign tuning_d              = res_d_ff;
  assign test_two_analog       = test_analog_ff;

endmodule

// ==== inc/synth_cfg_pkg.sv ====
// Package: register map, field layout and reset values of the synthesizer configuration bank
package synth_cfg_pkg;
  localparam logic [5:0] ADDR_RES_A      = 6'h20;
  localparam logic [5:0] ADDR_RX_BIAS    = 6'h21;
  localparam logic [5:0] ADDR_TX_BIAS    = 6'h22;
  localparam logic [5:0] ADDR_CAL_PUMP   = 6'h23;
  localparam logic [5:0] ADDR_CAL_OSC    = 6'h24;
  localparam logic [5:0] ADDR_CAL_COARSE = 6'h25;
  localparam logic [5:0] ADDR_CAL_CTRL   = 6'h26;
  localparam logic [5:0] ADDR_RES_B      = 6'h29;
  localparam logic [5:0] ADDR_RES_C      = 6'h2a;
  localparam logic [5:0] ADDR_RES_D      = 6'h2b;
  localparam logic [5:0] ADDR_TEST_TWO   = 6'h2c;

  localparam logic [7:0] RST_RES_A       = 8'hf8;
  localparam logic [7:0] RST_RX_BIAS     = 8'h56;
  localparam logic [7:0] RST_TX_BIAS     = 8'h10;
  localparam logic [7:0] RST_CAL_PUMP    = 8'ha9;
  localparam logic [7:0] RST_CAL_OSC     = 8'h0a;
  localparam logic [7:0] RST_CAL_COARSE  = 8'h20;
  localparam logic [7:0] RST_CAL_CTRL    = 8'h0d;
  localparam logic [7:0] RST_RES_B       = 8'h59;
  localparam logic [7:0] RST_RES_C       = 8'h7f;
  localparam logic [7:0] RST_RES_D       = 8'h3f;
  localparam logic [7:0] RST_TEST_TWO    = 8'h88;
  localparam logic [7:0] WAKE_TEST_RET   = 8'h81;

  // Writable-bit masks; zero bits ignore writes and read as zero
  localparam logic [7:0] MASK_RES_A      = 8'hfb;
  localparam logic [7:0] MASK_TX_BIAS    = 8'h37;
  localparam logic [7:0] MASK_CAL_OSC    = 8'h3f;
  localparam logic [7:0] MASK_CAL_COARSE = 8'h3f;
  localparam logic [7:0] MASK_CAL_CTRL   = 8'h7f;

  localparam int POWER_IDX_LSB  = 0;
  localparam int PUMP_EN_LSB    = 4;
  localparam int PUMP_CODE_LSB  = 0;
  localparam int CORE_HIGH_BIT  = 5;
  localparam int OSC_CUR_LSB    = 0;
  localparam int COARSE_LSB     = 0;
  localparam int POWER_TABLE_DEPTH = 2;
endpackage

// ==== bench/synth_cfg_props.sv ====
// Checker: port properties of the synthesizer configuration bank
module synth_cfg_props (
  input wire logic       clk,
  input wire logic       sys_rst,
  input wire logic       wr_en,
  input wire logic       rd_en,
  input wire logic [5:0] addr,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] rd_data,
  input wire logic       wake_event,
  input wire logic       converter_retention_option,
  input wire logic [2:0] amp_power_index,
  input wire logic       pump_cal_stage_enable,
  input wire logic       osc_core_high_select,
  input wire logic [7:0] test_two_analog
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_wake_rd;
    wake_event ##1 !wr_en ##1 (rd_en && addr == 6'h2c);
  endsequence
  property p_power; wr_en && addr == 6'h22 |=> amp_power_index == 3'($past(wr_data)); endproperty
  a_power: assert property (p_power) else $error("power index");
  property p_pump; wr_en && addr == 6'h23 |=> pump_cal_stage_enable == (($past(wr_data) & 8'h30) != 8'h00); endproperty
  a_pump: assert property (p_pump) else $error("pump enable");
  property p_core; wr_en && addr == 6'h24 |=> osc_core_high_select == (($past(wr_data) & 8'h20) != 8'h00); endproperty
  a_core: assert property (p_core) else $error("core select");
  property p_wake_hi; wake_event && converter_retention_option |-> ##1 test_two_analog == 8'h81; endproperty
  a_wake_hi: assert property (p_wake_hi) else $error("wake value");
  property p_wake_lo; wake_event && !converter_retention_option |=> test_two_analog == 8'h88; endproperty
  a_wake_lo: assert property (p_wake_lo) else $error("wake value");
  property p_wake_rd; s_wake_rd |=> rd_data == 8'h88; endproperty
  a_wake_rd: assert property (p_wake_rd) else $error("wake read");
  property p_unused_a; rd_en && addr == 6'h20 |=> rd_data[2] == 1'b0; endproperty
  a_unused_a: assert property (p_unused_a) else $error("unused bit");
  property p_unused_tx; rd_en && addr == 6'h22 |=> (rd_data & 8'hc8) == 8'h00; endproperty
  a_unused_tx: assert property (p_unused_tx) else $error("unused bits");
endmodule
bind radio_frontend_synth_cfg_regs synth_cfg_props i_props (.clk, .sys_rst, .wr_en, .rd_en, .addr, .wr_data,
  .rd_data, .wake_event, .converter_retention_option, .amp_power_index, .pump_cal_stage_enable,
  .osc_core_high_select, .test_two_analog);

// ==== bench/host_model.sv ====
// Host model: register writes and reads over the configuration port
module host_model (
  input  wire logic       clk,
  output logic            wr_en,
  output logic            rd_en,
  output logic      [5:0] addr,
  output logic      [7:0] wr_data,
  input  wire logic [7:0] rd_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 6'h00;
    wr_data = 8'h00;
  end
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk) #1;
    wr_en = 1'b1;
    addr = a;
    wr_data = v;
    @(posedge clk) #1;
    wr_en = 1'b0;
    wr_data = ~v;
  endtask
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk) #1;
    rd_en = 1'b1;
    addr = a;
    @(posedge clk) #1;
    rd_en = 1'b0;
    v = rd_data;
  endtask
  task automatic set_mod(input logic ook);
    wr(6'h22, ook ? 8'h01 : 8'h00);
  endtask
  task automatic restore(input logic [7:0] v);
    for (int i = 0; i < 4; i++) wr(6'h29 + 6'(i), v);
  endtask
endmodule

// ==== bench/tb_radio_frontend_synth_cfg_regs.sv ====
// Testbench: reset values, readback, power select, calibration and wake
module tb_radio_frontend_synth_cfg_regs;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic sys_rst, wr_en, rd_en, rd_hit, sleep_active, wake_event, converter_retention_option, cal_result_valid;
  logic pump_cal_stage_enable, osc_core_high_select;
  logic [2:0] amp_power_index;
  logic [3:0] cal_pump_code, pump_current_code;
  logic [4:0] cal_osc_current, osc_current_code;
  logic [5:0] addr, cal_coarse, coarse_tune_code;
  logic [7:0] wr_data, rd_data, power_entry_0, power_entry_1, selected_power, test_two_analog, d;
  logic [7:0] rx_bias, tuning_b, tuning_c, tuning_d;
  logic [6:0] cal_control;
  int err_total = 0, checks_done = 0, cycles = 0;
  // Rows: address, reset value, readback after writing ff
  logic [23:0] rows [12] = '{24'h20f8fb, 24'h2156ff, 24'h221037, 24'h23a9ff, 24'h240a3f, 24'h25203f,
                             24'h260d7f, 24'h270000, 24'h2959ff, 24'h2a7fff, 24'h2b3fff, 24'h2c88ff};
  always #12.5 clk = ~clk;
  radio_frontend_synth_cfg_regs i_dut (.clk, .sys_rst, .wr_en, .rd_en, .addr, .wr_data, .rd_data, .rd_hit,
    .sleep_active, .wake_event, .converter_retention_option, .cal_result_valid, .cal_pump_code, .cal_osc_current,
    .cal_coarse, .power_entry_0, .power_entry_1, .selected_power, .amp_power_index, .pump_cal_stage_enable,
    .pump_current_code, .osc_core_high_select, .osc_current_code, .coarse_tune_code, .rx_bias, .cal_control,
    .tuning_b, .tuning_c, .tuning_d, .test_two_analog);
  host_model i_host (.clk, .wr_en, .rd_en, .addr, .wr_data, .rd_data);
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_total++;
      wrap_up();
    end
  end
  initial begin
    sys_rst = 1'b1;
    {sleep_active, wake_event, converter_retention_option, cal_result_valid} = 4'h0;
    {cal_pump_code, cal_osc_current, cal_coarse} = 15'h0000;
    power_entry_0 = 8'h3c;
    power_entry_1 = 8'hc3;
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    chk("rx bias", rx_bias, 8'h56);
    chk("cal control", {1'b0, cal_control}, 8'h0d);
    foreach (rows[i]) begin
      i_host.rd(rows[i][21:16], d);
      chk("reset", d, rows[i][15:8]);
      i_host.wr(rows[i][21:16], 8'hff);
      i_host.rd(rows[i][21:16], d);
      chk("readback", d, rows[i][7:0]);
    end
    chk("hit", {7'h00, rd_hit}, 8'h01);
    chk("rx bias", rx_bias, 8'hff);
    chk("cal control", {1'b0, cal_control}, 8'h7f);
    $display("register table done");
    i_host.set_mod(1'b1);
    @(posedge clk) #1;
    chk("power", selected_power, 8'hc3);
    i_host.wr(6'h22, 8'h02);
    @(posedge clk) #1;
    chk("power", selected_power, 8'h3c);
    $display("power select done");
    i_host.wr(6'h23, 8'h09);
    chk("pump enable", {7'h00, pump_cal_stage_enable}, 8'h00);
    {cal_pump_code, cal_osc_current, cal_coarse, cal_result_valid} = {4'h6, 5'h13, 6'h2a, 1'b1};
    @(posedge clk) #1;
    cal_result_valid = 1'b0;
    chk("pump code", {4'h0, pump_current_code}, 8'h06);
    chk("osc current", {3'h0, osc_current_code}, 8'h13);
    chk("coarse", {2'h0, coarse_tune_code}, 8'h2a);
    i_host.wr(6'h24, 8'h15);
    chk("core", {7'h00, osc_core_high_select}, 8'h00);
    chk("osc override", {3'h0, osc_current_code}, 8'h15);
    $display("calibration done");
    sleep_active = 1'b1;
    i_host.wr(6'h29, 8'h00);
    i_host.rd(6'h29, d);
    chk("sleep write", d, 8'hff);
    {wake_event, converter_retention_option} = 2'b11;
    @(posedge clk) #1;
    {wake_event, sleep_active} = 2'b00;
    chk("analog", test_two_analog, 8'h81);
    i_host.rd(6'h2c, d);
    chk("wake read", d, 8'h88);
    i_host.rd(6'h29, d);
    chk("reload", d, 8'h59);
    chk("tuning c", tuning_c, 8'h7f);
    chk("tuning d", tuning_d, 8'h3f);
    {wake_event, converter_retention_option} = 2'b10;
    @(posedge clk) #1;
    wake_event = 1'b0;
    chk("analog", test_two_analog, 8'h88);
    i_host.restore(8'h5a);
    i_host.rd(6'h2b, d);
    chk("restore", d, 8'h5a);
    chk("tuning b", tuning_b, 8'h5a);
    chk("tuning c", tuning_c, 8'h5a);
    chk("tuning d", tuning_d, 8'h5a);
    chk("analog", test_two_analog, 8'h5a);
    $display("sleep and wake done");
    sys_rst = 1'b1;
    @(posedge clk) #1;
    chk("reset power", selected_power, 8'h00);
    chk("reset analog", test_two_analog, 8'h88);
    sys_rst = 1'b0;
    i_host.rd(6'h22, d);
    chk("reset index", d, 8'h10);
    $display("mid-run reset done");
    wrap_up();
  end
endmodule
